// >>> src/ccr_pkg.sv
// Shared constants and types for the core control register bank
package ccr_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [3:0] CCR_IDX_UNLOCK = 4'h4;
    localparam logic [3:0] CCR_IDX_SP_LOW = 4'hD;
    localparam logic [3:0] CCR_IDX_SP_HIGH = 4'hE;
    localparam logic [3:0] CCR_IDX_STATUS = 4'hF;
    // Unlock signatures
    localparam logic [7:0] CCR_KEY_SELF_PROGRAM = 8'h9D;
    localparam logic [7:0] CCR_KEY_IO_UNLOCK = 8'hD8;
    // Unlock key read-back bit positions
    localparam int CCR_UNLOCK_IO_BIT = 0;
    localparam int CCR_UNLOCK_SPM_BIT = 1;
    // Status flag positions
    localparam int CCR_FLAG_I = 7;
    localparam int CCR_FLAG_T = 6;
    // Reset values
    localparam logic [7:0] CCR_UNLOCK_RESET = 8'h00;
    localparam logic [7:0] CCR_STATUS_RESET = 8'h00;
    localparam logic [15:0] CCR_SP_RESET = 16'h3FFF;
    // Instructions that a window or a guard lasts
    localparam logic [2:0] CCR_WINDOW_INSTRS = 3'h4;
    // Status register layout, bit 7 first
    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } ccr_status_t;
    // Arithmetic flags reported by the execution unit
    typedef struct packed {
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } ccr_alu_flags_t;
endpackage : ccr_pkg

// >>> src/ccr_instr_window.sv
// Window that stays open for a fixed number of executed instructions
`timescale 1ns/1ps
`default_nettype none
module ccr_instr_window
    import ccr_pkg::*;
#(
    parameter logic [2:0] LENGTH = CCR_WINDOW_INSTRS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic open_pulse,
    input wire logic instr_step,
    input wire logic kill,
    output logic active
);
    logic [2:0] count_q;
    logic [2:0] count_d;
    logic active_q;
    logic active_d;

    ////////////////////////////////////////////////////////////////////////
    // Opening wins over a kill so the opening write never closes itself
    always_comb begin
        count_d = count_q;
        active_d = active_q;
        if (open_pulse) begin
            count_d = LENGTH;
            active_d = 1'b1;
        end else if (kill) begin
            count_d = 3'h0;
            active_d = 1'b0;
        end else if (active_q && instr_step) begin
            count_d = count_q - 3'h1;
            active_d = (count_q != 3'h1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 3'h0;
            active_q <= 1'b0;
        end else begin
            count_q <= count_d;
            active_q <= active_d;
        end
    end

    assign active = active_q;
endmodule : ccr_instr_window
`default_nettype wire

// >>> src/ccr_stack_ptr.sv
// Stack pointer with byte-wise write through a temporary low byte
`timescale 1ns/1ps
`default_nettype none
module ccr_stack_ptr
    import ccr_pkg::*;
#(
    parameter int SP_W = 16,
    parameter logic [15:0] SP_RESET = CCR_SP_RESET
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    input wire logic push,
    input wire logic pop,
    input wire logic step_two,
    output logic [15:0] stack_ptr
);
    // Bits above SP_W are not built and read as zero
    localparam logic [15:0] SP_MASK = 16'(({17'h0, 1'b1} << SP_W) - 18'h1);

    logic [15:0] sp_q;
    logic [15:0] sp_d;
    logic [7:0] temp_q;
    logic [7:0] temp_d;
    logic [15:0] step;

    ////////////////////////////////////////////////////////////////////////
    // High byte write beats push or pop in the same cycle
    always_comb begin
        step = step_two ? 16'h0002 : 16'h0001;
        sp_d = sp_q;
        temp_d = temp_q;
        if (wr_low) begin
            temp_d = wdata;
        end
        if (wr_high) begin
            sp_d = {wdata, temp_q} & SP_MASK;
        end else if (push) begin
            sp_d = (sp_q - step) & SP_MASK;
        end else if (pop) begin
            sp_d = (sp_q + step) & SP_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= SP_RESET & SP_MASK;
            temp_q <= 8'h00;
        end else begin
            sp_q <= sp_d;
            temp_q <= temp_d;
        end
    end

    // unbuilt bits held zero in sp_q
    assign stack_ptr = sp_q;
endmodule : ccr_stack_ptr
`default_nettype wire

// >>> src/ccr_core_regs.sv
// Core control registers: unlock key, stack pointer and status flags
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ccr_core_regs
    import ccr_pkg::*;
#(
    parameter int ADR_W = 6,
    parameter int SP_W = 16,
    parameter logic [15:0] SP_RESET = CCR_SP_RESET
) (
    input wire logic clk,
    input wire logic rst_n,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Execution unit events
    input wire logic instr_retire,
    input wire logic core_io_write,
    input wire logic core_nvm_access,
    input wire logic core_sleep,
    input wire logic prot_wr_req,
    input wire logic spm_exec_req,
    input wire logic flags_we,
    input wire ccr_alu_flags_t flags_in,
    input wire logic bit_store_instr,
    input wire logic bit_store_val,
    input wire logic gie_set,
    input wire logic gie_clear,
    input wire logic sp_push,
    input wire logic sp_pop,
    input wire logic sp_step_two,
    // Results toward the core
    output logic prot_wr_grant,
    output logic spm_grant,
    output logic irq_block,
    output logic irq_allow,
    output ccr_status_t status_flags,
    output logic [15:0] stack_ptr
);
    ////////////////////////////////////////////////////////////////////////
    // Address decode shared by read and write paths
    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [3:0] idx);
        hit = (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
    endfunction : hit

    logic req;
    logic ack_q;
    logic ack_d;
    logic wait_q;
    logic wait_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic take;
    logic bus_wr;
    logic [7:0] wbyte;
    logic gie_change;
    logic io_open;
    logic spm_open;
    logic io_kill;
    logic spm_kill;
    logic guard_open;
    logic guard_kill;
    logic io_active;
    logic spm_active;
    logic guard_active;
    logic grant_io_d;
    logic grant_spm_d;
    logic grant_io_q;
    logic grant_spm_q;
    logic block_d;
    logic block_q;
    logic allow_q;
    ccr_status_t stat_q;
    ccr_status_t stat_d;

    // Request qualifier and the one byte lane in use
    assign req = wb_cyc_i && wb_stb_i;
    assign wbyte = wb_dat_i[7:0];
    // Only byte lane 0 carries register data
    assign bus_wr = take && wb_we_i && wb_sel_i[0];

    // Per-register write strobes, decoded once; the wait-state check (gie_change) decodes its own status write
    logic wr_key;
    logic wr_sp_low;
    logic wr_sp_high;
    logic wr_status;
    assign wr_key = bus_wr && hit(wb_adr_i, CCR_IDX_UNLOCK);
    assign wr_sp_low = bus_wr && hit(wb_adr_i, CCR_IDX_SP_LOW);
    assign wr_sp_high = bus_wr && hit(wb_adr_i, CCR_IDX_SP_HIGH);
    assign wr_status = bus_wr && hit(wb_adr_i, CCR_IDX_STATUS);

    assign gie_change = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, CCR_IDX_STATUS)
        && (wbyte[CCR_FLAG_I] != stat_q.i);

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: ack one cycle after the request, or two with a wait
    always_comb begin
        ack_d = 1'b0;
        wait_d = 1'b0;
        take = 1'b0;
        if (req && !ack_q) begin
            if (gie_change && !wait_q) begin
                wait_d = 1'b1;
            end else begin
                ack_d = 1'b1;
                take = 1'b1;
            end
        end
    end

    // Read mux; unmapped addresses read zero and writes there are dropped
    always_comb begin
        dat_d = dat_q;
        if (take && !wb_we_i) begin
            dat_d = 32'h0000_0000;
            if (hit(wb_adr_i, CCR_IDX_UNLOCK)) begin
                dat_d[CCR_UNLOCK_IO_BIT] = io_active;
                dat_d[CCR_UNLOCK_SPM_BIT] = spm_active;
            end
            if (hit(wb_adr_i, CCR_IDX_SP_LOW)) begin
                dat_d[7:0] = stack_ptr[7:0];
            end
            // High byte read direct, no temporary copy
            if (hit(wb_adr_i, CCR_IDX_SP_HIGH)) begin
                dat_d[7:0] = stack_ptr[15:8];
            end
            if (hit(wb_adr_i, CCR_IDX_STATUS)) begin
                dat_d[7:0] = stat_q;
            end
        end
    end

    // Bus registers; ack cleared by reset so no stray answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            wait_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            wait_q <= wait_d;
            dat_q <= dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlock windows and the stack guard
    // key write opens window
    assign io_open = wr_key && (wbyte == CCR_KEY_IO_UNLOCK);
    assign spm_open = wr_key && (wbyte == CCR_KEY_SELF_PROGRAM);
    assign guard_open = wr_sp_low;

    assign grant_io_d = prot_wr_req && io_active;
    assign grant_spm_d = spm_exec_req && spm_active;

    assign io_kill = core_io_write || core_nvm_access || core_sleep || bus_wr || grant_io_d;
    assign spm_kill = core_nvm_access || core_sleep || grant_spm_d;
    assign guard_kill = core_io_write || bus_wr;

    // I/O register unlock window
    ccr_instr_window #(.LENGTH(CCR_WINDOW_INSTRS)) u_io_window (
        .clk(clk),
        .rst_n(rst_n),
        .open_pulse(io_open),
        .instr_step(instr_retire),
        .kill(io_kill),
        .active(io_active)
    );

    // Self-program window; bus writes do not end it
    ccr_instr_window #(.LENGTH(CCR_WINDOW_INSTRS)) u_spm_window (
        .clk(clk),
        .rst_n(rst_n),
        .open_pulse(spm_open),
        .instr_step(instr_retire),
        .kill(spm_kill),
        .active(spm_active)
    );

    // Stack guard; any bus write or core I/O write ends it early
    ccr_instr_window #(.LENGTH(CCR_WINDOW_INSTRS)) u_sp_guard (
        .clk(clk),
        .rst_n(rst_n),
        .open_pulse(guard_open),
        .instr_step(instr_retire),
        .kill(guard_kill),
        .active(guard_active)
    );

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer; high byte sits one index above the low byte
    // byte placement
    ccr_stack_ptr #(.SP_W(SP_W), .SP_RESET(SP_RESET)) u_stack_ptr (
        .clk(clk),
        .rst_n(rst_n),
        .wr_low(wr_sp_low),
        .wr_high(wr_sp_high),
        .wdata(wbyte),
        .push(sp_push),
        .pop(sp_pop),
        .step_two(sp_step_two),
        .stack_ptr(stack_ptr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status flags; a bus write overrides a core update in the same cycle
    always_comb begin
        stat_d = stat_q;
        if (gie_set) begin
            stat_d.i = 1'b1;
        end else if (gie_clear) begin
            stat_d.i = 1'b0;
        end
        if (bit_store_instr) begin
            stat_d.t = bit_store_val;
        end
        if (flags_we) begin
            stat_d.h = flags_in.h;
            stat_d.v = flags_in.v;
            stat_d.n = flags_in.n;
            stat_d.z = flags_in.z;
            stat_d.c = flags_in.c;
        end
        if (wr_status) begin
            stat_d = wbyte;
        end
        // sign forced to n xor v
        stat_d.s = stat_d.n ^ stat_d.v;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt gating from the open windows and the global enable
    // windows block interrupts
    assign block_d = io_active || spm_active || guard_active;

    // Flags and grants registered so every output is a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= CCR_STATUS_RESET;
            grant_io_q <= 1'b0;
            grant_spm_q <= 1'b0;
            block_q <= 1'b0;
            allow_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            grant_io_q <= grant_io_d;
            grant_spm_q <= grant_spm_d;
            block_q <= block_d;
            allow_q <= stat_d.i && !block_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from their registers
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign prot_wr_grant = grant_io_q;
    assign spm_grant = grant_spm_q;
    assign irq_block = block_q;
    assign irq_allow = allow_q;
    assign status_flags = stat_q;
endmodule : ccr_core_regs
`default_nettype wire

// >>> tb/ccr_core_regs_checker.sv
// Port-level assertions for the core control register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_core_regs_checker
    import ccr_pkg::*;
#(
    parameter int ADR_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic prot_wr_req,
    input wire logic flags_we,
    input wire ccr_alu_flags_t flags_in,
    input wire logic gie_clear,
    input wire logic prot_wr_grant,
    input wire logic irq_block,
    input wire logic irq_allow,
    input wire ccr_status_t status_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Fresh byte-lane write; ack low excludes the answer cycle
    wire logic [3:0] idx = wb_adr_i[5:2];
    wire logic wr0 = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    // First request cycle only: the wait cycle also shows ack low
    sequence s_gie_wr;
        $rose(wb_cyc_i && wb_stb_i) && wr0 && idx == CCR_IDX_STATUS && wb_dat_i[7] != status_flags.i;
    endsequence
    sequence s_sp_low_wr; wr0 && idx == CCR_IDX_SP_LOW; endsequence
    property p_gie_wait; s_gie_wr |=> !wb_ack_o ##1 wb_ack_o; endproperty
    a_gie_wait: assert property (p_gie_wait) else $error("no wait state on enable change");
    property p_key_rd; wb_ack_o && !wb_we_i && idx == CCR_IDX_UNLOCK |-> wb_dat_o[31:2] == 30'h0; endproperty
    a_key_rd: assert property (p_key_rd) else $error("key upper bits not zero");
    property p_sign; status_flags.s == (status_flags.n ^ status_flags.v); endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");
    // Bus cycles excluded: a bus status write overrides core updates
    property p_flags;
        flags_we && !wb_cyc_i |=> {status_flags.h, status_flags.v, status_flags.n, status_flags.z,
            status_flags.c} == $past(flags_in);
    endproperty
    a_flags: assert property (p_flags) else $error("arithmetic flags not stored");
    property p_allow; irq_allow |-> status_flags.i && !irq_block; endproperty
    a_allow: assert property (p_allow) else $error("interrupt allowed while blocked");
    property p_gie_hold; $fell(status_flags.i) |-> $past(gie_clear || (wb_cyc_i && wb_we_i)); endproperty
    a_gie_hold: assert property (p_gie_hold) else $error("enable cleared by hardware");
    property p_grant; prot_wr_grant |-> $past(prot_wr_req); endproperty
    a_grant: assert property (p_grant) else $error("grant without request");
    property p_sp_guard; s_sp_low_wr |=> ##[1:2] irq_block; endproperty
    a_sp_guard: assert property (p_sp_guard) else $error("stack write did not block");
endmodule : ccr_core_regs_checker

bind ccr_core_regs ccr_core_regs_checker #(.ADR_W(ADR_W)) u_chk (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .prot_wr_req, .flags_we, .flags_in,
    .gie_clear, .prot_wr_grant, .irq_block, .irq_allow, .status_flags);
`default_nettype wire

// >>> tb/ccr_core_model.sv
// Behavioural execution unit that raises core events
`timescale 1ns/1ps
`default_nettype none
module ccr_core_model
    import ccr_pkg::*;
(
    input wire logic clk,
    output var logic [13:0] ev,
    output var ccr_alu_flags_t flags
);
    ////////////////////////////////////////
    // Idle from time zero so nothing fires out of reset
    initial begin
        ev = 14'h0000;
        flags = 5'h00;
    end
    // One step: events last one clock, flags scrambled once unqualified
    task automatic op(input logic [13:0] m, input ccr_alu_flags_t f);
        @(posedge clk);
        ev <= m;
        flags <= f;
        @(posedge clk);
        ev <= 14'h0000;
        flags <= ~f;
        @(negedge clk);
    endtask : op
endmodule : ccr_core_model
`default_nettype wire

// >>> tb/ccr_testbench.sv
// Self-checking bench for the core control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ccr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [5:0] wb_adr = 6'h00;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] rdat;
    logic ack, grant, spm_gr, blk, allow;
    logic [13:0] ev;
    logic [15:0] sp, r;
    ccr_alu_flags_t fl, f;
    ccr_status_t st;
    int n_fail = 0;
    int n_tests = 0;
    int cyc;
    ////////////////////////////////////////
    // 100 MHz clock
    always #5 clk = ~clk;
    // Narrow stack pointer shows the unbuilt bits reading zero
    ccr_core_regs #(.SP_W(14)) dut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .instr_retire(ev[0]), .core_io_write(ev[1]), .core_nvm_access(ev[2]), .core_sleep(ev[3]),
        .prot_wr_req(ev[4]), .spm_exec_req(ev[5]), .flags_we(ev[6]), .flags_in(fl),
        .bit_store_instr(ev[7]), .bit_store_val(ev[8]), .gie_set(ev[9]), .gie_clear(ev[10]),
        .sp_push(ev[11]), .sp_pop(ev[12]), .sp_step_two(ev[13]), .prot_wr_grant(grant),
        .spm_grant(spm_gr), .irq_block(blk), .irq_allow(allow), .status_flags(st), .stack_ptr(sp)
    );
    ccr_core_model core (.clk(clk), .ev(ev), .flags(fl));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle: request held until ack is sampled, cyc counts edges
    task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d);
        cyc = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= {24'h00_0000, d};
        wb_sel <= 4'h1;
        do begin
            @(posedge clk);
            cyc++;
        end while (ack !== 1'b1 && cyc < 50);
        if (cyc >= 50) begin
            n_fail++;
            stop_test();
        end
        r = rdat[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_sel <= 4'h0;
        wb_dat <= ~wb_dat;
        @(negedge clk);
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        bus(1'b0, a, 8'h00);
        chk(r, e);
    endtask : rd
    // Open for three instructions, shut after the fourth; reads never kill
    task automatic win(input logic [15:0] k);
        rd(6'h10, k);
        repeat (3) core.op(14'h0001, 5'h00);
        rd(6'h10, k);
        chk(16'(blk), 16'h0001);
        core.op(14'h0001, 5'h00);
        rd(6'h10, 16'h0000);
        chk(16'(blk), 16'h0000);
    endtask : win
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    // Hang guard far beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        stop_test();
    end
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        chk(sp, 16'h3FFF);
        rd(6'h34, 16'h00FF);
        rd(6'h38, 16'h003F);
        rd(6'h10, 16'h0000);
        rd(6'h3C, 16'h0000);
        rd(6'h00, 16'h0000);
        // Low byte first; pair commits on the high byte
        bus(1'b1, 6'h34, 8'hFF);
        win(16'h0000);
        bus(1'b1, 6'h38, 8'hFF);
        chk(sp, 16'h3FFF);
        bus(1'b1, 6'h34, 8'h21);
        chk(sp, 16'h3FFF);
        chk(16'(blk), 16'h0001);
        bus(1'b1, 6'h38, 8'h12);
        chk(sp, 16'h1221);
        chk(16'(blk), 16'h0000);
        rd(6'h34, 16'h0021);
        rd(6'h38, 16'h0012);
        core.op(14'h0800, 5'h00);
        core.op(14'h2800, 5'h00);
        core.op(14'h1000, 5'h00);
        chk(sp, 16'h121F);
        bus(1'b1, 6'h10, 8'hD8);
        win(16'h0001);
        bus(1'b1, 6'h10, 8'h9D);
        win(16'h0002);
        bus(1'b1, 6'h10, 8'hFF);
        rd(6'h10, 16'h0000);
        core.op(14'h0030, 5'h00);
        chk({14'h0000, grant, spm_gr}, 16'h0000);
        // Core write, memory access and sleep each close the window
        for (int k = 1; k < 4; k++) begin
            bus(1'b1, 6'h10, 8'hD8);
            core.op(14'h0001 << k, 5'h00);
            core.op(14'h0010, 5'h00);
            chk(16'(grant), 16'h0000);
        end
        bus(1'b1, 6'h10, 8'hD8);
        core.op(14'h0010, 5'h00);
        chk(16'(grant), 16'h0001);
        rd(6'h10, 16'h0000);
        bus(1'b1, 6'h10, 8'h9D);
        core.op(14'h0010, 5'h00);
        chk(16'(grant), 16'h0000);
        core.op(14'h0020, 5'h00);
        chk(16'(spm_gr), 16'h0001);
        core.op(14'h0020, 5'h00);
        chk(16'(spm_gr), 16'h0000);
        // Wait state only when the enable bit really changes
        bus(1'b1, 6'h3C, 8'h80);
        chk(cyc[15:0], 16'h0003);
        chk(16'(allow), 16'h0001);
        bus(1'b1, 6'h3C, 8'h90);
        chk(cyc[15:0], 16'h0002);
        rd(6'h3C, 16'h0080);
        bus(1'b1, 6'h10, 8'hD8);
        chk(16'(allow), 16'h0000);
        core.op(14'h0008, 5'h00);
        @(negedge clk);
        chk(16'(allow), 16'h0001);
        core.op(14'h0400, 5'h00);
        chk({14'h0000, st.i, allow}, 16'h0000);
        core.op(14'h0600, 5'h00);
        chk(16'(st.i), 16'h0001);
        for (int k = 0; k < 32; k += 9) begin
            f = 5'(k);
            core.op(14'h0040, f);
            chk({8'h00, st}, {10'h002, f.h, f.n ^ f.v, f.v, f.n, f.z, f.c});
        end
        core.op(14'h0180, 5'h00);
        chk(16'(st.t), 16'h0001);
        core.op(14'h0080, 5'h00);
        chk(16'(st.t), 16'h0000);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
